// [pkg/drpis_pkg.sv]
package drpis_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int          CLK_PERIOD_NS   = 25;       // ref clock, 40 MHz
   localparam int          INIT_ENTRY_CLKS = 1024;     // low clocks before pll init mode
   localparam int          INIT_LEN_CLKS   = 1024;     // length of pll init phase
   localparam int          LOCK_TIME_NS    = 100000;   // pll lock interval, 100 us
   // least time, so round up to whole cycles
   localparam int          LOCK_CYC        = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] ENTRY_LAST      = 12'(INIT_ENTRY_CLKS - 1);
   localparam logic [11:0] INIT_LAST       = 12'(INIT_LEN_CLKS - 1);
   localparam logic [11:0] LOCK_LAST       = 12'(LOCK_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // boot selection, high pin then low pin
   localparam logic [1:0]  BOOT_NONE       = 2'h0;
   localparam logic [1:0]  BOOT_HOST       = 2'h1;
   localparam logic [1:0]  BOOT_BAD        = 2'h2;
   localparam logic [1:0]  BOOT_SELF       = 2'h3;
   localparam logic [15:0] RESET_ENTRY     = 16'h0200;
   localparam logic [2:0]  MULT_RST        = 3'h0;     // ratio x1 until first init

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [2:0] {
      ST_COUNT, ST_PLLINIT, ST_LOCK, ST_HELD, ST_BOOTSEL, ST_BOOT, ST_EXEC, ST_BADSEL
   } drpis_state_t;

   typedef struct packed {
      logic       dev_rst_n;
      logic       boot_sel_hi;
      logic       boot_sel_lo;
      logic [2:0] mult_sel;
   } drpis_pins_t;

   typedef struct packed {
      drpis_state_t st;
      logic [11:0]  cnt;
      logic [2:0]   mult;
      logic [1:0]   mode;
      logic         boot_start;
      logic         boot_err;
      logic         core_rst_n;
      logic         clk_en;
      logic         pll_init;
      logic         mem_undef;
      logic         fetch_en;
   } drpis_regs_t;

   localparam drpis_regs_t REGS_RST = '{st: ST_COUNT, cnt: 12'h000, mult: MULT_RST, mode: BOOT_NONE,
                                        boot_start: 1'b0, boot_err: 1'b0, core_rst_n: 1'b0,
                                        clk_en: 1'b1, pll_init: 1'b0, mem_undef: 1'b0,
                                        fetch_en: 1'b0};

endpackage

// [verilog/drpis_sync.sv]
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module drpis_sync #(
   parameter int W = 6
) (
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         nrst_in,
   // data
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta_r <= '0;
         q_out  <= '0;
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end
endmodule

// [verilog/drpis_seq.sv]
`timescale 1ns/1ps
module drpis_seq (
   // clock and reset
   input  wire logic        CLK_IN,
   input  wire logic        NRST_IN,
   // device pins
   input  wire logic        DEV_RST_N_IN,
   input  wire logic        BOOT_SEL_HI_IN,
   input  wire logic        BOOT_SEL_LO_IN,
   input  wire logic [2:0]  MULT_SEL_IN,
   // boot engine, same clock
   input  wire logic        BOOT_DONE_IN,
   output logic             BOOT_START_OUT,
   output logic      [1:0]  BOOT_MODE_OUT,
   output logic             BOOT_ERR_OUT,
   // core control
   output logic             CORE_RST_N_OUT,
   output logic             SYS_CLK_EN_OUT,
   output logic      [2:0]  PLL_MULT_OUT,
   output logic             PLL_INIT_OUT,
   output logic             MEM_UNDEF_OUT,
   output logic             FETCH_EN_OUT,
   output logic      [15:0] FETCH_ADDR_OUT
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation
   drpis_pkg::drpis_pins_t pins_raw;
   drpis_pkg::drpis_pins_t pins_s;
   drpis_pkg::drpis_regs_t regs_r;
   drpis_pkg::drpis_regs_t regs_nxt;
   logic                   rst_high;
   logic [1:0]             sel;

   assign pins_raw = '{dev_rst_n: DEV_RST_N_IN, boot_sel_hi: BOOT_SEL_HI_IN,
                       boot_sel_lo: BOOT_SEL_LO_IN, mult_sel: MULT_SEL_IN};

   drpis_sync #(.W($bits(drpis_pkg::drpis_pins_t))) u_drpis_sync (
      .clk_in  (CLK_IN),
      .nrst_in (NRST_IN),
      .d_in    (pins_raw),
      .q_out   (pins_s)
   );

   assign rst_high = pins_s.dev_rst_n;
   assign sel      = {pins_s.boot_sel_hi, pins_s.boot_sel_lo};

   ////////////////////////////////////////////////////////////////////////////
   // state decode helpers
   // core leaves reset only once the pin is released
   function automatic logic core_running(input drpis_pkg::drpis_state_t s);
      core_running = (s == drpis_pkg::ST_BOOTSEL) || (s == drpis_pkg::ST_BOOT) ||
                     (s == drpis_pkg::ST_EXEC) || (s == drpis_pkg::ST_BADSEL);
   endfunction

   // pll output not yet trustworthy
   function automatic logic pll_unstable(input drpis_pkg::drpis_state_t s);
      pll_unstable = (s == drpis_pkg::ST_PLLINIT) || (s == drpis_pkg::ST_LOCK);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      regs_nxt            = regs_r;
      regs_nxt.boot_start = 1'b0;
      case (regs_r.st)
         drpis_pkg::ST_COUNT: begin
            if (rst_high) begin
               // early release: ordinary reset, multiplier untouched
               regs_nxt.st  = drpis_pkg::ST_BOOTSEL;
               regs_nxt.cnt = 12'h000;
            end else if (regs_r.cnt == drpis_pkg::ENTRY_LAST) begin
               regs_nxt.st        = drpis_pkg::ST_PLLINIT;
               regs_nxt.cnt       = 12'h000;
               regs_nxt.mult      = pins_s.mult_sel;
               regs_nxt.mem_undef = 1'b1;
            end else begin
               regs_nxt.cnt = regs_r.cnt + 12'h001;
            end
         end
         // pin is ignored here: releasing now is the controller's fault
         drpis_pkg::ST_PLLINIT: begin
            if (regs_r.cnt == drpis_pkg::INIT_LAST) begin
               regs_nxt.st  = drpis_pkg::ST_LOCK;
               regs_nxt.cnt = 12'h000;
            end else begin
               regs_nxt.cnt = regs_r.cnt + 12'h001;
            end
         end
         drpis_pkg::ST_LOCK: begin
            if (regs_r.cnt == drpis_pkg::LOCK_LAST) begin
               regs_nxt.st  = drpis_pkg::ST_HELD;
               regs_nxt.cnt = 12'h000;
            end else begin
               regs_nxt.cnt = regs_r.cnt + 12'h001;
            end
         end
         drpis_pkg::ST_HELD: begin
            if (rst_high) begin
               regs_nxt.st = drpis_pkg::ST_BOOTSEL;
            end
         end
         // pins sampled two clocks after release, inside the stable window
         drpis_pkg::ST_BOOTSEL: begin
            regs_nxt.mode     = sel;
            regs_nxt.boot_err = 1'b0;
            case (sel)
               drpis_pkg::BOOT_NONE: begin
                  regs_nxt.st       = drpis_pkg::ST_EXEC;
                  regs_nxt.fetch_en = 1'b1;
               end
               drpis_pkg::BOOT_BAD: begin
                  regs_nxt.st       = drpis_pkg::ST_BADSEL;
                  regs_nxt.boot_err = 1'b1;
               end
               default: begin
                  regs_nxt.st         = drpis_pkg::ST_BOOT;
                  regs_nxt.boot_start = 1'b1;
               end
            endcase
         end
         drpis_pkg::ST_BOOT: begin
            if (BOOT_DONE_IN) begin
               regs_nxt.st        = drpis_pkg::ST_EXEC;
               regs_nxt.fetch_en  = 1'b1;
               regs_nxt.mem_undef = 1'b0;
            end
         end
         drpis_pkg::ST_EXEC: begin
            regs_nxt.fetch_en = 1'b1;
         end
         drpis_pkg::ST_BADSEL: begin
            regs_nxt.fetch_en = 1'b0;
         end
         default: begin
            regs_nxt.st = drpis_pkg::ST_COUNT;
         end
      endcase
      // a low pin after release restarts the reset count
      if (!rst_high && core_running(regs_r.st)) begin
         regs_nxt.st         = drpis_pkg::ST_COUNT;
         regs_nxt.cnt        = 12'h000;
         regs_nxt.fetch_en   = 1'b0;
         regs_nxt.boot_start = 1'b0;
      end
      regs_nxt.core_rst_n = core_running(regs_nxt.st);
      regs_nxt.clk_en     = !pll_unstable(regs_nxt.st);
      regs_nxt.pll_init   = (regs_nxt.st == drpis_pkg::ST_PLLINIT);
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         regs_r <= drpis_pkg::REGS_RST;
      end else begin
         regs_r <= regs_nxt;
      end
   end

   // outputs straight from the state register, fetch address from RESET_ENTRY
   assign BOOT_START_OUT = regs_r.boot_start;
   assign BOOT_MODE_OUT  = regs_r.mode;
   assign BOOT_ERR_OUT   = regs_r.boot_err;
   assign CORE_RST_N_OUT = regs_r.core_rst_n;
   assign SYS_CLK_EN_OUT = regs_r.clk_en;
   assign PLL_MULT_OUT   = regs_r.mult;
   assign PLL_INIT_OUT   = regs_r.pll_init;
   assign MEM_UNDEF_OUT  = regs_r.mem_undef;
   assign FETCH_EN_OUT   = regs_r.fetch_en;
   assign FETCH_ADDR_OUT = drpis_pkg::RESET_ENTRY;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!NRST_IN);

   property p_enter_init;
      regs_r.st == drpis_pkg::ST_COUNT && regs_r.cnt == drpis_pkg::ENTRY_LAST && !rst_high
      |=> PLL_INIT_OUT && MEM_UNDEF_OUT;
   endproperty
   a_enter_init: assert property (p_enter_init) else $error("pll init not entered");

   property p_init_len;
      regs_r.st == drpis_pkg::ST_PLLINIT && regs_r.cnt == drpis_pkg::INIT_LAST
      |=> regs_r.st == drpis_pkg::ST_LOCK && !PLL_INIT_OUT && !SYS_CLK_EN_OUT;
   endproperty
   a_init_len: assert property (p_init_len) else $error("init phase length wrong");

   property p_lock_end;
      regs_r.st == drpis_pkg::ST_LOCK && regs_r.cnt == drpis_pkg::LOCK_LAST
      |=> regs_r.st == drpis_pkg::ST_HELD && SYS_CLK_EN_OUT;
   endproperty
   a_lock_end: assert property (p_lock_end) else $error("lock interval end wrong");

   property p_clk_gated;
      PLL_INIT_OUT |-> !SYS_CLK_EN_OUT ##1 !SYS_CLK_EN_OUT;
   endproperty
   a_clk_gated: assert property (p_clk_gated) else $error("clock enabled during pll init");

   property p_low_resets;
      !rst_high && CORE_RST_N_OUT |=> !CORE_RST_N_OUT && !FETCH_EN_OUT;
   endproperty
   a_low_resets: assert property (p_low_resets) else $error("core not reset on low pin");

   property p_fetch_entry;
      FETCH_EN_OUT |-> FETCH_ADDR_OUT == 16'h0200 && CORE_RST_N_OUT && regs_r.st == drpis_pkg::ST_EXEC;
   endproperty
   a_fetch_entry: assert property (p_fetch_entry) else $error("fetch outside reset entry");

   property p_host_boot;
      regs_r.st == drpis_pkg::ST_BOOTSEL && rst_high && sel == 2'h1
      |=> BOOT_START_OUT && BOOT_MODE_OUT == 2'h1 ##1 !BOOT_START_OUT;
   endproperty
   a_host_boot: assert property (p_host_boot) else $error("host boot not started");

   property p_bad_sel;
      regs_r.st == drpis_pkg::ST_BOOTSEL && rst_high && sel == 2'h2
      |=> BOOT_ERR_OUT && !BOOT_START_OUT && !FETCH_EN_OUT;
   endproperty
   a_bad_sel: assert property (p_bad_sel) else $error("prohibited boot select accepted");

   property p_mult_kept;
      PLL_MULT_OUT != $past(PLL_MULT_OUT) |-> PLL_INIT_OUT && regs_r.mult == $past(pins_s.mult_sel);
   endproperty
   a_mult_kept: assert property (p_mult_kept) else $error("multiplier changed outside init");

   property p_cnt_restart;
      regs_r.st == drpis_pkg::ST_COUNT && rst_high |=> regs_r.cnt == 12'h000 && !PLL_INIT_OUT;
   endproperty
   a_cnt_restart: assert property (p_cnt_restart) else $error("count not restarted");

   cover property (regs_r.st == drpis_pkg::ST_HELD ##[1:20] FETCH_EN_OUT);
   cover property (regs_r.st == drpis_pkg::ST_COUNT && rst_high && regs_r.cnt != 12'h000);
   cover property (BOOT_START_OUT ##[1:50] FETCH_EN_OUT);
   cover property (BOOT_ERR_OUT);

endmodule

// [verification/drpis_ctrl_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// board reset controller: owns the device reset pin and the boot pins
module drpis_ctrl_model (
   // clock
   input  wire logic clk_in,
   // device pins
   output logic      dev_rst_n_out,
   output logic      sel_hi_out,
   output logic      sel_lo_out
);
   // pin idles high, device starts from its own NRST_IN reset
   initial begin
      dev_rst_n_out = 1'b1;
      sel_hi_out    = 1'b0;
      sel_lo_out    = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins from the last release stay put 12 clocks, then 4 high clocks
   task automatic assert_rst(input logic [1:0] sel);
      repeat (12) @(posedge clk_in);
      repeat (4) @(posedge clk_in);
      dev_rst_n_out <= 1'b0;
      sel_hi_out    <= sel[1];
      sel_lo_out    <= sel[0];
   endtask

   // caller decides the low time, long holds cover init and lock
   task automatic release_rst();
      @(posedge clk_in);
      dev_rst_n_out <= 1'b1;
   endtask
endmodule

// [verification/test_dsp_reset_pll_init_sequencer.sv]
`timescale 1ns/1ps
module test_dsp_reset_pll_init_sequencer;
   logic        clk, nrst_n, dev_rst_n, sel_hi, sel_lo, boot_done;
   logic [2:0]  mult_sel, pll_mult;
   logic        boot_start, boot_err, core_rst_n, sys_clk_en, pll_init, mem_undef, fetch_en;
   logic [1:0]  boot_mode;
   logic [15:0] fetch_addr;
   int          n_errors, num_checks, cycles;

   ////////////////////////////////////////////////////////////////////////////
   // 40 MHz reference clock
   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   drpis_ctrl_model u_drpis_ctrl_model (.clk_in(clk), .dev_rst_n_out(dev_rst_n),
      .sel_hi_out(sel_hi), .sel_lo_out(sel_lo));

   drpis_seq u_drpis_seq (.CLK_IN(clk), .NRST_IN(nrst_n), .DEV_RST_N_IN(dev_rst_n),
      .BOOT_SEL_HI_IN(sel_hi), .BOOT_SEL_LO_IN(sel_lo), .MULT_SEL_IN(mult_sel),
      .BOOT_DONE_IN(boot_done), .BOOT_START_OUT(boot_start), .BOOT_MODE_OUT(boot_mode),
      .BOOT_ERR_OUT(boot_err), .CORE_RST_N_OUT(core_rst_n), .SYS_CLK_EN_OUT(sys_clk_en),
      .PLL_MULT_OUT(pll_mult), .PLL_INIT_OUT(pll_init), .MEM_UNDEF_OUT(mem_undef),
      .FETCH_EN_OUT(fetch_en), .FETCH_ADDR_OUT(fetch_addr));

   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // hang guard, whole run is about 9200 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         n_errors++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // release, watch the boot choice, then finish the boot if one started
   task automatic release_and_boot(input logic [1:0] sel);
      int   starts;
      logic booted;
      starts = 0;
      booted = (sel == drpis_pkg::BOOT_HOST || sel == drpis_pkg::BOOT_SELF);
      u_drpis_ctrl_model.release_rst();
      repeat (8) begin
         @(posedge clk);
         #1;
         if (boot_start === 1'b1) starts++;
      end
      chk("core_rst_n_run", 1'b1, core_rst_n);
      chk("boot_starts", {15'h0, booted}, 16'(starts));
      chk("boot_mode", sel, boot_mode);
      chk("boot_err", sel == drpis_pkg::BOOT_BAD, boot_err);
      chk("fetch_before_done", sel == drpis_pkg::BOOT_NONE, fetch_en);
      if (booted) begin
         @(posedge clk);
         boot_done <= 1'b1;
         @(posedge clk);
         boot_done <= 1'b0;
         @(posedge clk);
         #1;
         chk("fetch_after_done", 1'b1, fetch_en);
         chk("mem_undef_cleared", 1'b0, mem_undef);
      end
      chk("fetch_addr", drpis_pkg::RESET_ENTRY, fetch_addr);
   endtask

   // long hold: init entry, init length, lock gap, then host boot
   task automatic long_reset();
      int n;
      u_drpis_ctrl_model.assert_rst(drpis_pkg::BOOT_HOST);
      repeat (4) @(posedge clk);
      #1;
      chk("core_rst_n_low", 1'b0, core_rst_n);
      chk("fetch_en_low", 1'b0, fetch_en);
      n = 4;
      while (pll_init !== 1'b1 && n < 1100) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("init_entry_ok", 1'b1, n >= 1024 && n <= 1030);
      chk("sys_clk_en_init", 1'b0, sys_clk_en);
      chk("mem_undef_init", 1'b1, mem_undef);
      chk("pll_mult_init", 3'h5, pll_mult);
      n = 0;
      while (pll_init === 1'b1 && n < 1100) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("init_len", 16'(drpis_pkg::INIT_LEN_CLKS), 16'(n));
      n = 0;
      while (sys_clk_en !== 1'b1 && n < 4100) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("lock_len", 16'(drpis_pkg::LOCK_CYC), 16'(n));
      release_and_boot(drpis_pkg::BOOT_HOST);
   endtask

   // just under the entry count, three times in a row, so the counter must restart
   task automatic short_reset(input logic [1:0] sel);
      int seen;
      seen = 0;
      @(posedge clk);
      mult_sel <= 3'h2;
      u_drpis_ctrl_model.assert_rst(sel);
      repeat (1000) begin
         @(posedge clk);
         #1;
         if (pll_init === 1'b1 || sys_clk_en !== 1'b1) seen++;
      end
      chk("no_pll_init", 16'h0000, 16'(seen));
      chk("core_rst_n_held", 1'b0, core_rst_n);
      release_and_boot(sel);
      chk("pll_mult_kept", 3'h5, pll_mult);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      nrst_n     = 1'b0;
      mult_sel   = 3'h5;
      boot_done  = 1'b0;
      n_errors   = 0;
      num_checks = 0;
      cycles     = 0;
      // reset spans 12 edges: 11 here, released at the 12th
      repeat (11) @(posedge clk);
      #1;
      chk("core_rst_n_por", 1'b0, core_rst_n);
      chk("pll_mult_por", drpis_pkg::MULT_RST, pll_mult);
      @(posedge clk);
      nrst_n <= 1'b1;
      long_reset();
      short_reset(drpis_pkg::BOOT_SELF);
      short_reset(drpis_pkg::BOOT_NONE);
      short_reset(drpis_pkg::BOOT_BAD);
      complete_run();
   end
endmodule
